// ---- wkt_pkg.sv ----
/*
 * wkt_pkg: register map, field layout, reset values and encodings of the
 * 32-bit wake-up timer.
 * assumes: every user writes package::name; nothing is imported.
 */
package wkt_pkg;

   // ===========================================================================
   // register map (byte addresses)
   localparam logic [31:0] RELOAD_ADDR    = 32'hFFFF0340;
   localparam logic [31:0] COUNT_ADDR     = 32'hFFFF0344;
   localparam logic [31:0] CONTROL_ADDR   = 32'hFFFF0348;
   localparam logic [31:0] CLEAR_ADDR     = 32'hFFFF034C;
   localparam logic [31:0] CAPTURE_ADDR   = 32'hFFFF0350;

   // ===========================================================================
   // reset values
   localparam logic [31:0] RELOAD_RESET   = 32'h00000000;
   localparam logic [31:0] COUNT_RESET    = 32'h0FFFFFFF;
   localparam logic [10:0] CONTROL_RESET  = 11'h000;
   localparam logic [31:0] CAPTURE_RESET  = 32'h00000000;

   // ===========================================================================
   // control field positions
   localparam int          CTL_PRESC_LSB  = 0;
   localparam int          CTL_FMT_LSB    = 4;
   localparam int          CTL_MODE_BIT   = 6;
   localparam int          CTL_EN_BIT     = 7;
   localparam int          CTL_UP_BIT     = 8;
   localparam int          CTL_SRC_LSB    = 9;
   localparam int          CTL_WIDTH      = 11;

   // ===========================================================================
   // encodings
   typedef enum logic [1:0] {
      SRC_CORE,
      SRC_LP_OSC,
      SRC_XTAL,
      SRC_PREC_OSC
   } wkt_src_type;

   localparam logic [1:0]  FMT_BINARY     = 2'h0;
   localparam logic [1:0]  FMT_HMS_23     = 2'h2;
   localparam logic [1:0]  FMT_HMS_255    = 2'h3;

   // time-of-day layout: hours 31:24, minutes 21:16, seconds 13:8, hundredths 6:0
   localparam logic [6:0]  HUND_MAX       = 7'h63;
   localparam logic [5:0]  SEC_MAX        = 6'h3B;
   localparam logic [5:0]  MIN_MAX        = 6'h3B;
   localparam logic [7:0]  HOUR_MAX_23    = 8'h17;
   localparam logic [7:0]  HOUR_MAX_255   = 8'hFF;

   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

// ---- wkt_prescale.sv ----
/*
 * wkt_prescale: power-of-two divider of the source tick stream.
 * assumes: tick_in is high for one clk cycle per tick; code 0..15 divides by 2**code.
 */
`timescale 1ns/1ps
`default_nettype none
module wkt_prescale (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       tick_in,
   input  wire logic [3:0] code,
   input  wire logic       clear,
   output logic            tick_out
);

   typedef struct packed {
      logic [14:0] cnt;
   } wkt_presc_state_type;

   wkt_presc_state_type s_q;
   wkt_presc_state_type s_d;
   logic [14:0]         mask;

   // 0000 -> /1, 0100 -> /16, 1000 -> /256, 1111 -> /32768
   assign mask     = 15'((16'h0001 << code) - 16'h0001);
   // masking keeps a code change from stranding the counter past its terminal
   assign tick_out = tick_in && ((s_q.cnt & mask) == mask);

   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d.cnt = 15'h0000;
      end else if (tick_out) begin
         s_d.cnt = 15'h0000;
      end else if (tick_in) begin
         s_d.cnt = s_q.cnt + 15'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule
`default_nettype wire

// ---- wkt_hms_step.sv ----
/*
 * wkt_hms_step: one step of a hours:minutes:seconds:hundredths value.
 * assumes: value fields already in range; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module wkt_hms_step (
   input  wire logic [31:0] value,
   input  wire logic        up,
   input  wire logic [7:0]  hour_max,
   output logic [31:0]      next,
   output logic             wrap
);

   logic [6:0] hund;
   logic [5:0] sec;
   logic [5:0] min;
   logic [7:0] hour;
   logic       c_hund;
   logic       c_sec;
   logic       c_min;

   always_comb begin
      hund   = value[6:0];
      sec    = value[13:8];
      min    = value[21:16];
      hour   = value[31:24];
      // carry or borrow out of each field
      c_hund = up ? (hund == wkt_pkg::HUND_MAX) : (hund == 7'h00);
      c_sec  = c_hund && (up ? (sec == wkt_pkg::SEC_MAX) : (sec == 6'h00));
      c_min  = c_sec && (up ? (min == wkt_pkg::MIN_MAX) : (min == 6'h00));
      wrap   = c_min && (up ? (hour >= hour_max) : (hour == 8'h00));
      if (up) begin
         hund = c_hund ? 7'h00 : hund + 7'h01;
         sec  = c_hund ? (c_sec ? 6'h00 : sec + 6'h01) : sec;
         min  = c_sec ? (c_min ? 6'h00 : min + 6'h01) : min;
         hour = c_min ? (wrap ? 8'h00 : hour + 8'h01) : hour;
      end else begin
         hund = c_hund ? wkt_pkg::HUND_MAX : hund - 7'h01;
         sec  = c_hund ? (c_sec ? wkt_pkg::SEC_MAX : sec - 6'h01) : sec;
         min  = c_sec ? (c_min ? wkt_pkg::MIN_MAX : min - 6'h01) : min;
         hour = c_min ? (wrap ? hour_max : hour - 8'h01) : hour;
      end
      next = {hour, 2'h0, min, 2'h0, sec, 1'h0, hund};
   end

endmodule
`default_nettype wire

// ---- wkt_wakeup_timer.sv ----
/*
 * wkt_wakeup_timer: 32-bit wake-up timer with AXI4-Lite register access,
 * four tick sources, power-of-two prescaler and optional time-of-day counting.
 * assumes: clk is the always-on 40 MHz bus clock; core_clk_en is a level from
 * the power controller on clk; the three 32.768 kHz inputs are asynchronous.
 */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wkt_wakeup_timer (
   input  wire logic        clk,
   input  wire logic        reset_n,
   // AXI4-Lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // clocking and system
   input  wire logic        core_clk_en,
   input  wire logic        lp_osc_32k,
   input  wire logic        xtal_32k,
   input  wire logic        prec_osc_32k,
   input  wire logic        timer_irq_enabled,
   output logic             wake_irq
);

   // ===========================================================================
   // reset release
   // reset enters at once but leaves on a clock edge, so no flop leaves it alone
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ===========================================================================
   // state
   typedef struct packed {
      logic [2:0]  sync1;
      logic [2:0]  sync2;
      logic [2:0]  prev;
      logic        aw_held;
      logic [31:0] awaddr;
      logic        w_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [31:0] reload;
      logic [31:0] count;
      logic [10:0] control;
      logic [31:0] capture;
      logic        irq;
   } wkt_state_type;

   wkt_state_type s_q;
   wkt_state_type s_d;

   // ===========================================================================
   // source edges
   logic [2:0] src_edge;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_edge
         assign src_edge[gi] = s_q.sync2[gi] && !s_q.prev[gi];
      end
   endgenerate

   // ===========================================================================
   // control decode
   wkt_pkg::wkt_src_type src_sel;
   logic                 run;
   logic                 periodic;
   logic                 up;
   logic [1:0]           fmt;
   logic                 fmt_hms;
   logic [7:0]           hour_max;
   logic                 src_tick;

   always_comb begin
      src_sel  = wkt_pkg::wkt_src_type'(s_q.control[wkt_pkg::CTL_SRC_LSB +: 2]);
      run      = s_q.control[wkt_pkg::CTL_EN_BIT];
      periodic = s_q.control[wkt_pkg::CTL_MODE_BIT];
      up       = s_q.control[wkt_pkg::CTL_UP_BIT];
      fmt      = s_q.control[wkt_pkg::CTL_FMT_LSB +: 2];
      // reserved format 01 counts as plain binary
      fmt_hms  = (fmt == wkt_pkg::FMT_HMS_23) || (fmt == wkt_pkg::FMT_HMS_255);
      hour_max = (fmt == wkt_pkg::FMT_HMS_255) ? wkt_pkg::HOUR_MAX_255 : wkt_pkg::HOUR_MAX_23;
      unique case (src_sel)
         // core clock gated off stops only this source; 32k sources keep ticking
         wkt_pkg::SRC_CORE:     src_tick = core_clk_en;
         wkt_pkg::SRC_LP_OSC:   src_tick = src_edge[0];
         wkt_pkg::SRC_XTAL:     src_tick = src_edge[1];
         wkt_pkg::SRC_PREC_OSC: src_tick = src_edge[2];
      endcase
   end

   // ===========================================================================
   // write decode
   logic        aw_take;
   logic        w_take;
   logic        wr_fire;
   logic        wr_reload;
   logic        wr_control;
   logic        wr_clear;
   logic        wr_known;
   logic        rd_take;
   logic        sel_reload;
   logic        sel_control;
   logic        sel_clear;
   logic        sel_known;

   // read-only registers take a write and ignore it; only unmapped addresses fail
   always_comb begin
      sel_reload  = 1'h0;
      sel_control = 1'h0;
      sel_clear   = 1'h0;
      sel_known   = 1'h1;
      unique case (s_q.awaddr)
         wkt_pkg::RELOAD_ADDR:  sel_reload  = 1'h1;
         wkt_pkg::CONTROL_ADDR: sel_control = 1'h1;
         wkt_pkg::CLEAR_ADDR:   sel_clear   = 1'h1;
         wkt_pkg::COUNT_ADDR:   sel_known   = 1'h1;
         wkt_pkg::CAPTURE_ADDR: sel_known   = 1'h1;
         default:               sel_known   = 1'h0;
      endcase
   end

   assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
   assign s_axi_wready  = !s_q.w_held && !s_q.bvalid;
   assign s_axi_arready = !s_q.rvalid;
   assign aw_take       = s_axi_awvalid && s_axi_awready;
   assign w_take        = s_axi_wvalid && s_axi_wready;
   assign rd_take       = s_axi_arvalid && s_axi_arready;
   // a write is carried out the cycle after both halves are held
   assign wr_fire       = s_q.aw_held && s_q.w_held && !s_q.bvalid;
   assign wr_reload     = wr_fire && sel_reload;
   assign wr_control    = wr_fire && sel_control;
   assign wr_clear      = wr_fire && sel_clear;
   assign wr_known      = sel_known;

   // ===========================================================================
   // read decode
   logic [31:0] rd_word;
   logic        rd_err;

   always_comb begin
      rd_word = 32'h00000000;
      rd_err  = 1'h0;
      unique case (s_axi_araddr)
         wkt_pkg::RELOAD_ADDR:  rd_word = s_q.reload;
         wkt_pkg::COUNT_ADDR:   rd_word = s_q.count;
         wkt_pkg::CONTROL_ADDR: rd_word = {21'h0, s_q.control};
         wkt_pkg::CAPTURE_ADDR: rd_word = s_q.capture;
         // the clear register is write-only and reads back as zero
         wkt_pkg::CLEAR_ADDR:   rd_word = 32'h00000000;
         default:               rd_err  = 1'h1;
      endcase
   end

   // ===========================================================================
   // reload write, one byte lane per strobe
   logic [31:0] reload_merged;

   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign reload_merged[8*gi +: 8] = s_q.wstrb[gi] ? s_q.wdata[8*gi +: 8] : s_q.reload[8*gi +: 8];
      end
   endgenerate

   // ===========================================================================
   // counting
   logic        presc_clear;
   logic        step;
   logic [31:0] bin_next;
   logic        bin_wrap;
   logic [31:0] hms_next;
   logic        hms_wrap;
   logic [31:0] cnt_next;
   logic        timeout;

   // restart the divider with the count so the first period after a reload is whole
   assign presc_clear = !run || wr_clear;

   wkt_prescale u_prescale (
      .clk      (clk),
      .rst_n    (rst_n),
      .tick_in  (run && src_tick),
      .code     (s_q.control[wkt_pkg::CTL_PRESC_LSB +: 4]),
      .clear    (presc_clear),
      .tick_out (step)
   );

   wkt_hms_step u_hms_step (
      .value    (s_q.count),
      .up       (up),
      .hour_max (hour_max),
      .next     (hms_next),
      .wrap     (hms_wrap)
   );

   always_comb begin
      bin_next = up ? s_q.count + 32'h00000001 : s_q.count - 32'h00000001;
      bin_wrap = up ? (s_q.count == 32'hFFFFFFFF) : (s_q.count == 32'h00000000);
      cnt_next = fmt_hms ? hms_next : bin_next;
      timeout  = step && (fmt_hms ? hms_wrap : bin_wrap);
   end

   // ===========================================================================
   // interrupt and capture events
   logic irq_set;
   logic irq_clr;
   logic cap_load;

   assign irq_set  = timeout;
   assign irq_clr  = wr_clear;
   // capture follows the enable level at the moment of the timeout
   assign cap_load = timeout && timer_irq_enabled;

   // ===========================================================================
   // next state
   always_comb begin
      s_d       = s_q;
      s_d.sync1 = {prec_osc_32k, xtal_32k, lp_osc_32k};
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;

      // write channel
      if (aw_take) begin
         s_d.aw_held = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
      end
      if (w_take) begin
         s_d.w_held = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb  = s_axi_wstrb;
      end
      if (wr_fire) begin
         s_d.aw_held = 1'b0;
         s_d.w_held  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = wr_known ? wkt_pkg::RESP_OKAY : wkt_pkg::RESP_SLVERR;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end

      if (wr_reload) begin
         s_d.reload = reload_merged;
      end
      if (wr_control) begin
         // only bits 10:0 exist; 31:11 are dropped and read as zero
         if (s_q.wstrb[0]) begin
            s_d.control[7:0] = s_q.wdata[7:0];
         end
         if (s_q.wstrb[1]) begin
            s_d.control[10:8] = s_q.wdata[10:8];
         end
      end

      // counter: a clear write reloads at once and wins over a step
      if (wr_clear) begin
         s_d.count = s_q.reload;
      end else if (step) begin
         if (timeout && periodic) begin
            s_d.count = s_q.reload;
         end else begin
            s_d.count = cnt_next;
         end
      end

      // interrupt: a timeout in the clearing cycle survives the clear
      if (irq_clr) begin
         s_d.irq = 1'b0;
      end
      if (irq_set) begin
         s_d.irq = 1'b1;
      end

      if (cap_load) begin
         s_d.capture = s_q.count;
      end

      // read channel
      if (rd_take) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = rd_word;
         s_d.rresp  = rd_err ? wkt_pkg::RESP_SLVERR : wkt_pkg::RESP_OKAY;
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   // ===========================================================================
   // registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q         <= '0;
         s_q.reload  <= wkt_pkg::RELOAD_RESET;
         s_q.count   <= wkt_pkg::COUNT_RESET;
         s_q.control <= wkt_pkg::CONTROL_RESET;
         s_q.capture <= wkt_pkg::CAPTURE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ===========================================================================
   // outputs
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp  = s_q.bresp;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rresp  = s_q.rresp;
   assign s_axi_rdata  = s_q.rdata;
   assign wake_irq     = s_q.irq;

endmodule
`default_nettype wire

// ---- wkt_properties.sv ----
/*
 * wkt_properties: bus handshake and interrupt checks for the wake-up timer.
 * assumes: bound onto wkt_wakeup_timer; a single clock domain; the bench offers
 * write address and data together.
 */
`timescale 1ns/1ps
`default_nettype none
module wkt_checker (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        core_clk_en,
   input wire logic        lp_osc_32k,
   input wire logic        xtal_32k,
   input wire logic        prec_osc_32k,
   input wire logic        wake_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ==========================================================================
   // helpers
   logic wr_hs;
   logic clr_hs;
   logic quiet;
   assign wr_hs  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign clr_hs = wr_hs && (s_axi_awaddr == wkt_pkg::CLEAR_ADDR);
   // no tick source active, so no timeout can race the clear
   assign quiet  = !core_clk_en && !lp_osc_32k && !xtal_32k && !prec_osc_32k;

   sequence s_clear_quiet;
      clr_hs && quiet && $past(quiet) ##1 quiet;
   endsequence
   sequence s_resp_late;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence

   // ==========================================================================
   // properties
   property p_wr_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_rd_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_wr_resp;
      wr_hs |=> s_resp_late;
   endproperty
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_irq_clear;
      s_clear_quiet |=> !wake_irq;
   endproperty
   // the clear lands one edge after its handshake, so both edges are exempt
   property p_irq_hold;
      wake_irq && !clr_hs && !$past(clr_hs) |=> wake_irq;
   endproperty

   a_wr_block: assert property (p_wr_block) else $error("write channel open during response");
   a_rd_block: assert property (p_rd_block) else $error("read address open during read data");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   a_wr_resp: assert property (p_wr_resp) else $error("write response timing wrong");
   a_rd_resp: assert property (p_rd_resp) else $error("read data late");
   a_irq_clear: assert property (p_irq_clear) else $error("clear write left interrupt up");
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt fell without clear");
endmodule
bind wkt_wakeup_timer wkt_checker i_wkt_checker (.*);
`default_nettype wire

// ---- testbench.sv ----
/*
 * testbench: directed register and counting scenarios for the wake-up timer.
 * assumes: tick inputs are held still around register writes.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk = 1'h0;
   logic        reset_n = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0;
   logic        s_axi_awvalid = 1'h0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'h0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'h0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic        s_axi_arvalid = 1'h0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'h0;
   logic [3:0]  srcs = 4'h0;
   logic        timer_irq_enabled = 1'h0;
   logic        wake_irq;
   int          errors = 0;
   int          checks = 0;

   wkt_wakeup_timer i_wkt_wakeup_timer (.*, .core_clk_en(srcs[0]), .lp_osc_32k(srcs[1]),
      .xtal_32k(srcs[2]), .prec_osc_32k(srcs[3]));

   always #12.5 clk = ~clk;

   // ==========================================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, b;
      logic [1:0] r;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do begin
         @(negedge clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         b = s_axi_bvalid;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end while (!b);
      // bvalid is left waiting one edge so every response is held through a stall
      s_axi_bready <= 1'h1;
      @(negedge clk);
      r = s_axi_bresp;
      @(posedge clk);
      s_axi_bready <= 1'h0;
      chk(r, er);
   endtask

   // data is judged only when an OKAY answer is expected
   task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta, v;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do begin
         @(negedge clk);
         ta = s_axi_arready;
         v = s_axi_rvalid;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'h0;
      end while (!v);
      // rvalid is left waiting one edge so the read data is held through a stall
      s_axi_rready <= 1'h1;
      @(negedge clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      s_axi_rready <= 1'h0;
      chk(r, er);
      if (er == wkt_pkg::RESP_OKAY) chk(d, ed);
   endtask

   // core source: level for n cycles; 32k sources: n slow rising edges
   task automatic step(input int src, input int n);
      if (src == 0) begin
         @(posedge clk);
         srcs <= 4'h1;
         repeat (n) @(posedge clk);
         srcs <= 4'h0;
      end else begin
         repeat (n) begin
            @(posedge clk);
            srcs <= 4'h1 << src;
            repeat (4) @(posedge clk);
            srcs <= 4'h0;
            repeat (3) @(posedge clk);
         end
      end
      repeat (6) @(posedge clk);
   endtask

   task automatic arm(input logic [31:0] ctl, input logic [31:0] rl);
      wr(wkt_pkg::CONTROL_ADDR, 32'h0, wkt_pkg::RESP_OKAY);
      wr(wkt_pkg::RELOAD_ADDR, rl, wkt_pkg::RESP_OKAY);
      wr(wkt_pkg::CONTROL_ADDR, ctl, wkt_pkg::RESP_OKAY);
      wr(wkt_pkg::CLEAR_ADDR, 32'h0, wkt_pkg::RESP_OKAY);
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_reset_and_map();
      rd(wkt_pkg::RELOAD_ADDR, 32'h0, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::COUNT_ADDR, 32'h0FFFFFFF, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::CONTROL_ADDR, 32'h0, wkt_pkg::RESP_OKAY);
      chk({31'h0, wake_irq}, 32'h0);
      wr(wkt_pkg::CONTROL_ADDR, 32'hFFFFF83F, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::CONTROL_ADDR, 32'h0000003F, wkt_pkg::RESP_OKAY);
      wr(wkt_pkg::COUNT_ADDR, 32'h12345678, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::COUNT_ADDR, 32'h0FFFFFFF, wkt_pkg::RESP_OKAY);
      wr(wkt_pkg::RELOAD_ADDR, 32'hA5C3961E, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::RELOAD_ADDR, 32'hA5C3961E, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::CLEAR_ADDR, 32'h0, wkt_pkg::RESP_OKAY);
      wr(32'hFFFF0380, 32'h1, wkt_pkg::RESP_SLVERR);
      rd(32'hFFFF0380, 32'h0, wkt_pkg::RESP_SLVERR);
   endtask

   task automatic t_periodic_down();
      arm(32'h000000C0, 32'h3);
      rd(wkt_pkg::COUNT_ADDR, 32'h3, wkt_pkg::RESP_OKAY);
      step(0, 4);
      chk({31'h0, wake_irq}, 32'h1);
      rd(wkt_pkg::COUNT_ADDR, 32'h3, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::CAPTURE_ADDR, 32'h0, wkt_pkg::RESP_OKAY);
      step(0, 2);
      chk({31'h0, wake_irq}, 32'h1);
      wr(wkt_pkg::CLEAR_ADDR, 32'hDEADBEEF, wkt_pkg::RESP_OKAY);
      chk({31'h0, wake_irq}, 32'h0);
      rd(wkt_pkg::COUNT_ADDR, 32'h3, wkt_pkg::RESP_OKAY);
      wr(wkt_pkg::CONTROL_ADDR, 32'h00000040, wkt_pkg::RESP_OKAY);
      step(0, 3);
      rd(wkt_pkg::COUNT_ADDR, 32'h3, wkt_pkg::RESP_OKAY);
   endtask

   task automatic t_up_free();
      timer_irq_enabled <= 1'h1;
      // reserved format 01 must count as plain binary
      arm(32'h00000190, 32'hFFFFFFFE);
      step(0, 3);
      rd(wkt_pkg::COUNT_ADDR, 32'h1, wkt_pkg::RESP_OKAY);
      rd(wkt_pkg::CAPTURE_ADDR, 32'hFFFFFFFF, wkt_pkg::RESP_OKAY);
      chk({31'h0, wake_irq}, 32'h1);
   endtask

   task automatic t_prescale();
      logic [3:0] codes [3] = '{4'h4, 4'h8, 4'hF};
      foreach (codes[i]) begin
         arm(32'h00000080 | codes[i], 32'h64);
         step(0, 2 << codes[i]);
         rd(wkt_pkg::COUNT_ADDR, 32'h62, wkt_pkg::RESP_OKAY);
      end
   endtask

   task automatic t_time_of_day();
      logic [7:0] hmax;
      for (int f = 2; f < 4; f++) begin
         hmax = (f == 2) ? wkt_pkg::HOUR_MAX_23 : wkt_pkg::HOUR_MAX_255;
         arm(32'h00000088 | (f << 4), 32'h0);
         step(0, 512);
         rd(wkt_pkg::COUNT_ADDR, {hmax, 2'h0, wkt_pkg::MIN_MAX, 2'h0, wkt_pkg::SEC_MAX, 1'h0, 7'h62},
            wkt_pkg::RESP_OKAY);
      end
   endtask

   task automatic t_sources();
      for (int s = 1; s < 4; s++) begin
         arm(32'h00000080 | (s << 9), 32'hA);
         step(s, 3);
         step(s % 3 + 1, 2);
         step(0, 5);
         rd(wkt_pkg::COUNT_ADDR, 32'h7, wkt_pkg::RESP_OKAY);
      end
   endtask

   task automatic close_out();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================================
   // main sequence and watchdog
   initial begin
      repeat (3) @(posedge clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge clk);
      t_reset_and_map();
      t_periodic_down();
      t_up_free();
      t_prescale();
      t_time_of_day();
      t_sources();
      close_out();
   end

   // about 68k cycles are needed, mostly the divide-by-32768 case
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
endmodule
`default_nettype wire
